// [design/dma_seq_defines.vh]
`ifndef DMA_SEQ_DEFINES_VH
`define DMA_SEQ_DEFINES_VH

`define DMA_MODE_HI 2
`define DMA_MODE_LO 0
`define DMA_NM1_HI 13
`define DMA_NM1_LO 4
`define DMA_RPOW_HI 17
`define DMA_RPOW_LO 14

`define DMA_MODE_STOP 3'h0
`define DMA_MODE_BASIC 3'h1
`define DMA_MODE_AUTO 3'h2
`define DMA_MODE_PING 3'h3

`define DMA_OFS_SRC 32'h0000_0000
`define DMA_OFS_DST 32'h0000_0004
`define DMA_OFS_CFG 32'h0000_0008
`define DMA_ALT_OFS 32'h0000_0200
`define DMA_XFER_STEP 32'h0000_0004

`define DMA_CFG_RST 32'h0000_0000
`define DMA_ADDR_RST 32'h0000_0000

`endif

// [design/dma_cycle_sequencer.v]
`timescale 1ns/10ps
`include "dma_seq_defines.vh"

module dma_cycle_sequencer #(
    parameter NCH = 21
) (
    // Clock and reset
    input wire clk,
    input wire sys_rst,
    // Channel control
    input wire [NCH-1:0] chan_en,
    input wire [NCH-1:0] chan_alt_sel,
    input wire [NCH-1:0] chan_prio_hi,
    input wire [31:0] table_base,
    // Requests from peripherals or software
    input wire [NCH-1:0] dma_req,
    // Memory master
    output reg mem_req_q,
    output reg mem_we_q,
    output reg [31:0] mem_addr_q,
    output reg [31:0] mem_wdata_q,
    input wire [31:0] mem_rdata,
    input wire mem_ack,
    // Status
    output reg [NCH-1:0] chan_done_q,
    output reg busy_q,
    output reg [4:0] active_chan_q
);

    // ****************************************
    // State encoding
    // ****************************************
    localparam S_IDLE = 3'h0;
    localparam S_CFG = 3'h1;
    localparam S_SRC = 3'h2;
    localparam S_DST = 3'h3;
    localparam S_RD = 3'h4;
    localparam S_WR = 3'h5;
    localparam S_WB = 3'h6;

    reg [NCH-1:0] req_s1_q;
    reg [NCH-1:0] req_s2_q;
    reg [NCH-1:0] cont_q;
    reg [NCH-1:0] flip_q;
    reg [2:0] state_q;
    reg [4:0] cur_q;
    reg sel_q;
    reg last_q;
    reg [31:0] cfg_q;
    reg [31:0] src_q;
    reg [31:0] dst_q;
    reg [31:0] data_q;
    reg [9:0] rem_q;
    reg [15:0] grp_q;

    wire [NCH-1:0] pend;
    wire [31:0] tab_base;
    wire [31:0] rem_ofs;
    wire [2:0] mode;
    wire [2:0] rd_mode;
    reg found;
    reg [4:0] pick;
    integer i;
    integer j;

    // ****************************************
    // Request synchronisers and arbitration
    // ****************************************
    always @(posedge clk)
    begin
        if (sys_rst)
        begin
            req_s1_q <= {NCH{1'b0}};
            req_s2_q <= {NCH{1'b0}};
        end
        else
        begin
            req_s1_q <= dma_req;
            req_s2_q <= req_s1_q;
        end
    end

    // A channel only competes while enabled, so one disabled before it is picked never touches the table.
    assign pend = chan_en & (req_s2_q | cont_q);

    // High-priority channels win first, then the lowest channel number.
    always @*
    begin
        found = 1'b0;
        pick = 5'h00;
        for (i = NCH - 1; i >= 0; i = i - 1)
        begin
            if (pend[i] && !chan_prio_hi[i])
            begin
                found = 1'b1;
                pick = i[4:0];
            end
        end
        for (i = NCH - 1; i >= 0; i = i - 1)
        begin
            if (pend[i] && chan_prio_hi[i])
            begin
                found = 1'b1;
                pick = i[4:0];
            end
        end
    end

    // ****************************************
    // Address arithmetic
    // ****************************************
    assign tab_base = table_base + (sel_q ? `DMA_ALT_OFS : 32'h0000_0000)
        + {23'h000000, cur_q, 4'h0};
    // The last transfer of the cycle lands exactly on the end pointers.
    assign rem_ofs = {20'h00000, rem_q, 2'h0};
    assign mode = cfg_q[`DMA_MODE_HI:`DMA_MODE_LO];
    assign rd_mode = mem_rdata[`DMA_MODE_HI:`DMA_MODE_LO];

    // ****************************************
    // Cycle sequencer
    // ****************************************
    always @(posedge clk)
    begin
        if (sys_rst)
        begin
            state_q <= S_IDLE;
            cont_q <= {NCH{1'b0}};
            flip_q <= {NCH{1'b0}};
            cur_q <= 5'h00;
            sel_q <= 1'b0;
            last_q <= 1'b0;
            cfg_q <= `DMA_CFG_RST;
            src_q <= `DMA_ADDR_RST;
            dst_q <= `DMA_ADDR_RST;
            data_q <= `DMA_ADDR_RST;
            rem_q <= 10'h000;
            grp_q <= 16'h0000;
            mem_req_q <= 1'b0;
            mem_we_q <= 1'b0;
            mem_addr_q <= `DMA_ADDR_RST;
            mem_wdata_q <= `DMA_CFG_RST;
            chan_done_q <= {NCH{1'b0}};
            busy_q <= 1'b0;
            active_chan_q <= 5'h00;
        end
        else
        begin
            chan_done_q <= {NCH{1'b0}};
            for (j = 0; j < NCH; j = j + 1)
            begin
                if (!chan_en[j])
                begin
                    cont_q[j] <= 1'b0;
                    flip_q[j] <= 1'b0;
                end
            end
            case (state_q)
                S_IDLE:
                begin
                    busy_q <= 1'b0;
                    if (found)
                    begin
                        cur_q <= pick;
                        sel_q <= chan_alt_sel[pick] ^ flip_q[pick];
                        cont_q[pick] <= 1'b0;
                        busy_q <= 1'b1;
                        active_chan_q <= pick;
                        state_q <= S_CFG;
                    end
                end
                S_CFG:
                begin
                    if (!mem_req_q)
                    begin
                        mem_req_q <= 1'b1;
                        mem_we_q <= 1'b0;
                        mem_addr_q <= tab_base + `DMA_OFS_CFG;
                    end
                    else if (mem_ack)
                    begin
                        mem_req_q <= 1'b0;
                        cfg_q <= mem_rdata;
                        rem_q <= mem_rdata[`DMA_NM1_HI:`DMA_NM1_LO];
                        grp_q <= 16'h0001 << mem_rdata[`DMA_RPOW_HI:`DMA_RPOW_LO];
                        if (rd_mode == `DMA_MODE_BASIC || rd_mode == `DMA_MODE_AUTO
                            || rd_mode == `DMA_MODE_PING)
                        begin
                            state_q <= S_SRC;
                        end
                        else
                        begin
                            // Stop or unused code: nothing moves and nothing is written.
                            flip_q[cur_q] <= 1'b0;
                            state_q <= S_IDLE;
                        end
                    end
                end
                S_SRC:
                begin
                    if (!mem_req_q)
                    begin
                        mem_req_q <= 1'b1;
                        mem_addr_q <= tab_base + `DMA_OFS_SRC;
                    end
                    else if (mem_ack)
                    begin
                        mem_req_q <= 1'b0;
                        src_q <= mem_rdata;
                        state_q <= S_DST;
                    end
                end
                S_DST:
                begin
                    if (!mem_req_q)
                    begin
                        mem_req_q <= 1'b1;
                        mem_addr_q <= tab_base + `DMA_OFS_DST;
                    end
                    else if (mem_ack)
                    begin
                        mem_req_q <= 1'b0;
                        dst_q <= mem_rdata;
                        state_q <= S_RD;
                    end
                end
                S_RD:
                begin
                    if (!mem_req_q)
                    begin
                        mem_req_q <= 1'b1;
                        mem_we_q <= 1'b0;
                        mem_addr_q <= src_q - rem_ofs;
                    end
                    else if (mem_ack)
                    begin
                        mem_req_q <= 1'b0;
                        data_q <= mem_rdata;
                        state_q <= S_WR;
                    end
                end
                S_WR:
                begin
                    if (!mem_req_q)
                    begin
                        mem_req_q <= 1'b1;
                        mem_we_q <= 1'b1;
                        mem_addr_q <= dst_q - rem_ofs;
                        mem_wdata_q <= data_q;
                    end
                    else if (mem_ack)
                    begin
                        mem_req_q <= 1'b0;
                        mem_we_q <= 1'b0;
                        if (rem_q == 10'h000)
                        begin
                            last_q <= 1'b1;
                            state_q <= S_WB;
                        end
                        else
                        begin
                            rem_q <= rem_q - 10'h001;
                            grp_q <= grp_q - 16'h0001;
                            if (grp_q == 16'h0001)
                            begin
                                // A full group ends on the group count with transfers still left.
                                last_q <= 1'b0;
                                state_q <= S_WB;
                            end
                            else
                            begin
                                state_q <= S_RD;
                            end
                        end
                    end
                end
                S_WB:
                begin
                    if (!mem_req_q)
                    begin
                        // Only the configuration word is written; pointers stay untouched.
                        mem_req_q <= 1'b1;
                        mem_we_q <= 1'b1;
                        mem_addr_q <= tab_base + `DMA_OFS_CFG;
                        mem_wdata_q <= {cfg_q[31:`DMA_NM1_HI+1], rem_q, cfg_q[3],
                            last_q ? `DMA_MODE_STOP : mode};
                    end
                    else if (mem_ack)
                    begin
                        mem_req_q <= 1'b0;
                        mem_we_q <= 1'b0;
                        state_q <= S_IDLE;
                        if (last_q)
                        begin
                            chan_done_q[cur_q] <= 1'b1;
                            if (mode == `DMA_MODE_PING)
                            begin
                                // The other structure is tried at once; invalid ends it.
                                flip_q[cur_q] <= ~flip_q[cur_q];
                                cont_q[cur_q] <= chan_en[cur_q];
                            end
                            else
                            begin
                                flip_q[cur_q] <= 1'b0;
                            end
                        end
                        else if (mode == `DMA_MODE_AUTO)
                        begin
                            // Basic waits for a fresh request instead.
                            cont_q[cur_q] <= chan_en[cur_q];
                        end
                        else
                        begin
                            cont_q[cur_q] <= 1'b0;
                        end
                    end
                end
                default:
                begin
                    state_q <= S_IDLE;
                    mem_req_q <= 1'b0;
                    mem_we_q <= 1'b0;
                end
            endcase
        end
    end

endmodule

// [testbench/mem_model.sv]
`timescale 1ns/10ps
module mem_model (
    // Sequencer side
    input wire clk,
    input wire req,
    input wire we,
    input wire [31:0] addr,
    input wire [31:0] wdata,
    input wire [3:0] dly,
    // Answer
    output logic [31:0] rdata,
    output logic ack
);
    // ****************************************
    // Word memory with a settable wait
    // ****************************************
    logic [31:0] m [0:1023];
    int wait_n;
    initial
    begin
        rdata = 32'h0;
        ack = 1'b0;
        wait_n = 0;
    end
    // Read data toggles outside the ack cycle, so a late sample never looks right.
    always @(posedge clk)
    begin
        ack <= 1'b0;
        rdata <= ~rdata;
        wait_n <= 0;
        if (req && !ack)
        begin
            wait_n <= wait_n + 1;
            if (wait_n >= dly)
            begin
                ack <= 1'b1;
                if (we)
                    m[addr[11:2]] <= wdata;
                else
                    rdata <= m[addr[11:2]];
            end
        end
    end
endmodule

// [testbench/dma_seq_props.sv]
`timescale 1ns/10ps
module dma_seq_props #(
    parameter NCH = 21
) (
    // Clock and table
    input wire clk,
    input wire sys_rst,
    input wire [31:0] table_base,
    // Memory master
    input wire mem_req_q,
    input wire mem_we_q,
    input wire [31:0] mem_addr_q,
    input wire [31:0] mem_wdata_q,
    input wire mem_ack,
    // Status
    input wire [NCH-1:0] chan_done_q,
    input wire busy_q
);
    // ****************************************
    // Bus and completion checks
    // ****************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);
    wire in_tab = (mem_addr_q - table_base) < 32'h400;
    sequence s_acc;
        mem_req_q && mem_ack;
    endsequence
    sequence s_end_wb;
        s_acc ##0 (mem_we_q && in_tab && mem_wdata_q[2:0] == 3'h0);
    endsequence
    sequence s_cfg_rd;
        mem_req_q && !mem_we_q && in_tab && mem_addr_q[3:0] == 4'h8;
    endsequence
    a_req_holds: assert property (mem_req_q && !mem_ack |=> mem_req_q
        && $stable(mem_addr_q) && $stable(mem_we_q) && $stable(mem_wdata_q))
        else $error("Request changed before ack.");
    a_idle_gap: assert property (s_acc |=> !mem_req_q)
        else $error("No idle cycle after access.");
    a_no_idle_access: assert property (mem_req_q |-> busy_q)
        else $error("Memory access while idle.");
    a_done_single: assert property ($onehot0(chan_done_q))
        else $error("Two completion pulses.");
    a_done_one_clk: assert property (chan_done_q != 0 |=> chan_done_q == 0)
        else $error("Completion pulse too long.");
    a_end_then_done: assert property (s_end_wb |-> ##[1:2] chan_done_q != 0)
        else $error("Final writeback without completion.");
    a_done_after_wb: assert property (chan_done_q != 0 |->
        $past(mem_ack && mem_we_q) || $past(mem_ack && mem_we_q, 2))
        else $error("Completion without writeback.");
    a_ptr_never_wr: assert property (mem_req_q && mem_we_q && in_tab
        |-> mem_addr_q[3:0] == 4'h8)
        else $error("Table write off the config word.");
    a_cfg_first: assert property ($rose(busy_q) |-> ##[1:2] s_cfg_rd)
        else $error("Group did not begin with config read.");
endmodule
bind dma_cycle_sequencer dma_seq_props #(.NCH(NCH)) props (.clk(clk), .sys_rst(sys_rst),
    .table_base(table_base), .mem_req_q(mem_req_q), .mem_we_q(mem_we_q),
    .mem_addr_q(mem_addr_q), .mem_wdata_q(mem_wdata_q), .mem_ack(mem_ack),
    .chan_done_q(chan_done_q), .busy_q(busy_q));

// [testbench/tb_top.sv]
`timescale 1ns/10ps
module tb_top;
    // ****************************************
    // Bench signals and monitor
    // ****************************************
    logic clk = 0;
    logic sys_rst = 1;
    logic [20:0] chan_en = 21'h1fffff, alt = 0, prio = 0, req = 0;
    logic [31:0] tbase = 32'h1000_0400;
    logic [31:0] rdata, maddr, wdata;
    logic [20:0] done;
    logic [4:0] act;
    logic [3:0] dly = 0;
    logic ack, mreq, we, busy;
    int miscompares = 0, n_compared = 0, cyc = 0, nwb = 0, first = -1;
    int dcnt [0:20];
    dma_cycle_sequencer uut (.clk(clk), .sys_rst(sys_rst), .chan_en(chan_en),
        .chan_alt_sel(alt), .chan_prio_hi(prio), .table_base(tbase), .dma_req(req),
        .mem_req_q(mreq), .mem_we_q(we), .mem_addr_q(maddr), .mem_wdata_q(wdata),
        .mem_rdata(rdata), .mem_ack(ack), .chan_done_q(done), .busy_q(busy),
        .active_chan_q(act));
    mem_model mem (.clk(clk), .req(mreq), .we(we), .addr(maddr), .wdata(wdata),
        .dly(dly), .rdata(rdata), .ack(ack));
    always #10 clk = ~clk;
    // Counts land by non-blocking update so waiting tasks read them race-free.
    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        for (int i = 0; i < 21; i++)
            if (done[i] === 1'b1)
            begin
                dcnt[i] <= dcnt[i] + 1;
                if (first < 0)
                    first <= i;
            end
        if (mreq && ack && we && maddr - tbase < 32'h400)
            nwb <= nwb + 1;
        if (cyc > 40000)
        begin
            miscompares = miscompares + 1;
            give_verdict;
        end
    end
    function automatic logic [31:0] ptr(input int i);
        return 32'h1000_0000 + 4 * i;
    endfunction
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic setup(input int ch, a, mode, n, r);
        int k, s, d;
        k = 256 + a * 128 + ch * 4;
        s = ch * 12 + 11;
        d = 512 + a * 256 + s;
        mem.m[k] = ptr(s);
        mem.m[k + 1] = ptr(d);
        mem.m[k + 2] = {14'h0, r[3:0], n[9:0] - 10'h1, 1'b0, mode[2:0]};
        for (int i = 0; i < n; i++)
        begin
            mem.m[s - i] = $urandom;
            mem.m[d - i] = ~mem.m[s - i];
        end
    endtask
    task automatic verify(input int ch, a, n);
        int k, s, d;
        k = 256 + a * 128 + ch * 4;
        s = ch * 12 + 11;
        d = 512 + a * 256 + s;
        check(mem.m[k + 2][2:0], 32'h0);
        check(mem.m[k], ptr(s));
        check(mem.m[k + 1], ptr(d));
        for (int i = 0; i < n; i++)
            check(mem.m[d - i], mem.m[s - i]);
    endtask
    task automatic wait_done(input int ch, k);
        int t;
        t = 0;
        while (dcnt[ch] < k && t < 3000)
        begin
            @(posedge clk);
            t++;
        end
        check(dcnt[ch], k);
    endtask
    task automatic run(input int ch, a, mode, n, r);
        nwb = 0;
        dcnt[ch] = 0;
        dly <= 4'($urandom_range(3, 0));
        alt[ch] <= a[0];
        setup(ch, a, mode, n, r);
        req[ch] <= 1'b1;
        repeat (4) @(posedge clk);
        if (mode != 1)
            req[ch] <= 1'b0;
        wait_done(ch, 1);
        check({27'h0, act}, 32'(ch));
        req[ch] <= 1'b0;
        @(posedge clk);
        check(nwb, (n + (1 << r) - 1) >> r);
        verify(ch, a, n);
    endtask
    task give_verdict;
        if (miscompares == 0 && n_compared > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    // ****************************************
    // Main sequence
    // ****************************************
    initial
    begin
        void'($urandom(8));
        for (int i = 0; i < 21; i++)
            dcnt[i] = 0;
        repeat (2) @(posedge clk);
        sys_rst <= 1'b0;
        @(negedge clk);
        check({mreq, we, busy, done, act}, 32'h0);
        @(posedge clk);
        run(2, 0, 1, 5, 1);
        run(4, 1, 2, 7, 2);
        run(0, 0, 1, 1, 0);
        run(20, 1, 2, 3, 4);
        for (int i = 0; i < 8; i++)
            run($urandom_range(20, 0), $urandom_range(1, 0), $urandom_range(2, 1),
                $urandom_range(9, 1), $urandom_range(3, 0));
        chan_en <= 21'h1fffbf;
        nwb = 0;
        dcnt[6] = 0;
        dcnt[7] = 0;
        setup(6, 0, 1, 2, 0);
        setup(7, 0, 0, 2, 0);
        req <= 21'h0000c0;
        repeat (150) @(posedge clk);
        req <= 21'h0;
        repeat (4) @(posedge clk);
        check(dcnt[6] + dcnt[7] + nwb, 32'h0);
        check(mem.m[286], 32'h0000_0010);
        chan_en <= 21'h1fffff;
        alt <= 21'h0;
        nwb = 0;
        dcnt[9] = 0;
        setup(9, 0, 3, 3, 4);
        req[9] <= 1'b1;
        setup(9, 1, 3, 2, 4);
        repeat (4) @(posedge clk);
        req[9] <= 1'b0;
        wait_done(9, 2);
        repeat (100) @(posedge clk);
        check(dcnt[9] + nwb, 32'h4);
        verify(9, 0, 3);
        verify(9, 1, 2);
        first = -1;
        dcnt[3] = 0;
        dcnt[5] = 0;
        prio[5] <= 1'b1;
        setup(3, 0, 1, 2, 0);
        setup(5, 0, 1, 2, 0);
        req <= 21'h000028;
        wait_done(5, 1);
        req[5] <= 1'b0;
        wait_done(3, 1);
        req <= 21'h0;
        check(first, 32'h5);
        verify(3, 0, 2);
        verify(5, 0, 2);
        give_verdict;
    end
endmodule
